// ==== core/fault_evt_if.sv ====
`timescale 1ns/1ns
interface fault_evt_if;
    logic oc_evt;
    logic cb_evt;
    logic pgood;
    logic latched;
    logic alert;
    modport seq  (output oc_evt, output cb_evt, output pgood, output latched, input alert);
    modport regs (input oc_evt, input cb_evt, input pgood, input latched, output alert);
endinterface

// ==== core/fault_regs.sv ====
`timescale 1ns/1ns
module fault_regs
    import hs_seq_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        por_ok,
    input  wire logic        clear,
    input  wire logic [7:0]  addr,
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    output logic [15:0]      rdata,
    output logic [7:0]       cfg,
    fault_evt_if.regs        ev
);
    logic        preset, oc, cb, next_preset, next_oc, next_cb;
    logic [15:0] mask, next_mask, diag;
    logic [7:0]  next_cfg;

    always_comb begin
        // Event set wins over a clear in the same cycle.
        next_preset = por_ok ? (preset & ~clear) : 1'b1;
        next_oc     = ev.oc_evt | (oc & ~clear);
        next_cb     = ev.cb_evt | (cb & ~clear);
        next_mask   = (wr && addr == ADDR_ALERT_SUPPRESS_MASK) ? wdata : mask;
        next_cfg    = (wr && addr == ADDR_PROTECTION_CONFIG) ? wdata[7:0] : cfg;
        diag        = '0;
        diag[BIT_DG_OC]      = oc;
        diag[BIT_DG_BREAKER] = cb;
        diag[BIT_DG_PGOOD]   = ev.pgood;
        diag[BIT_DG_LATCHED] = ev.latched;
        rdata = '0;
        unique case (addr)
            ADDR_SUMMARY_FAULT_WORD: begin
                rdata[BIT_SUM_INPUT]   = oc;
                rdata[BIT_SUM_PGOOD_N] = ~ev.pgood;
            end
            ADDR_INPUT_FAULT_STATUS:  rdata[BIT_IN_OC] = oc;
            ADDR_VENDOR_FAULT_STATUS: begin
                rdata[BIT_VND_PRESET]  = preset;
                rdata[BIT_VND_BREAKER] = cb;
            end
            ADDR_ALERT_SUPPRESS_MASK: rdata = mask;
            ADDR_PROTECTION_CONFIG:   rdata = {8'h00, cfg};
            ADDR_COMBINED_DIAG_FLAGS: rdata = diag;
            default:                  rdata = '0;
        endcase
        // The preset alert ignores the mask so software always sees defaults.
        ev.alert = (preset & por_ok) | (oc & ~mask[BIT_DG_OC])
                 | (cb & ~mask[BIT_DG_BREAKER]);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            preset <= 1'b1;
            oc     <= 1'b0;
            cb     <= 1'b0;
            mask   <= MASK_RESET;
            cfg    <= CFG_RESET;
        end else begin
            preset <= next_preset;
            oc     <= next_oc;
            cb     <= next_cb;
            mask   <= next_mask;
            cfg    <= next_cfg;
        end
    end

    chk_preset_until_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (preset && !clear) |=> preset)
        else $error("defaults flag dropped without a clear");
    chk_cb_sticky_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ev.cb_evt |=> cb)
        else $error("breaker event not recorded");
endmodule

// ==== core/hot_swap_fault_sequencer.sv ====
`timescale 1ns/1ns
module hot_swap_fault_sequencer
    import hs_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Supply comparators
    input  wire logic        i_por_ok,
    input  wire logic        i_undervoltage_lockout_ok,
    input  wire logic        i_overvoltage_lockout_high,
    // Timer comparators
    input  wire logic        i_timer_hi,
    input  wire logic        i_timer_mid,
    input  wire logic        i_timer_lo,
    // Limit comparators
    input  wire logic        i_cl_low_hit,
    input  wire logic        i_cl_high_hit,
    input  wire logic        i_pl_hit,
    input  wire logic        i_cb_low_hit,
    input  wire logic        i_cb_high_hit,
    input  wire logic        i_feedback_sense_above,
    // Strap pins
    input  wire logic        i_limit_select_pin,
    input  wire logic        i_breaker_select_pin,
    input  wire logic        i_retry_pin,
    // Register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic        i_clear_faults,
    output logic [15:0]      o_reg_rdata,
    // Gate control
    output logic             o_gate_strong_pd,
    output logic             o_gate_weak_pd,
    output logic             o_gate_source,
    output logic             o_cl_sel_high,
    output logic             o_cb_sel_high,
    // Timer control
    output logic             o_timer_ground,
    output logic             o_timer_chg_insert,
    output logic             o_timer_chg_fault,
    output logic             o_timer_dis_fast,
    output logic             o_timer_dis_slow,
    // Status pins
    output logic             o_power_good_output,
    input  wire logic        i_alert_line,
    output logic             o_alert_line,
    output logic             o_alert_line_oe
);
    // ------------------------------------------------------------
    // Shared state
    // ------------------------------------------------------------
    fault_evt_if ev ();
    seq_state_t  state, next_state;
    timer_mode_t tmode;
    logic [7:0]  cfg;
    logic [15:0] rdata;
    logic [3:0]  ramps, next_ramps;
    logic [4:0]  tries, next_tries;
    logic        ramp_up, next_ramp_up, inrush, next_inrush;
    logic        tm_hi_q, next_tm_hi_q, cb_q, next_cb_q;
    logic        slow_dis, next_slow_dis;
    logic        cl_high, cb_high, limiting, breaker, supply_ok, policy_latch;
    logic        t_ground, t_insert, t_fault, t_dfast, t_dslow;
    logic        g_strong, g_weak, g_src, timer_top, retry_allowed;
    logic [4:0]  retry_limit;

    function automatic logic pick(input logic [1:0] ovr, input logic pin);
        pick = (ovr == OVR_PIN) ? pin : (ovr == OVR_HIGH);
    endfunction

    function automatic logic [4:0] retry_count(input logic [2:0] code);
        retry_count = (code <= RETRY_NONE) ? 5'h00 : 5'(5'h01 << (code - 3'h2));
    endfunction

    // ------------------------------------------------------------
    // Selection and comparator decode
    // ------------------------------------------------------------
    always_comb begin
        cl_high   = pick(cfg[CFG_CL_LSB +: 2], i_limit_select_pin);
        cb_high   = pick(cfg[CFG_CB_LSB +: 2], i_breaker_select_pin);
        limiting  = (cl_high ? i_cl_high_hit : i_cl_low_hit) | i_pl_hit;
        breaker   = cb_high ? i_cb_high_hit : i_cb_low_hit;
        supply_ok = i_undervoltage_lockout_ok & ~i_overvoltage_lockout_high;
        timer_top = i_timer_hi & ~tm_hi_q;
        policy_latch  = (cfg[CFG_RETRY_LSB +: 3] == RETRY_PIN) ? i_retry_pin
                      : (cfg[CFG_RETRY_LSB +: 3] == RETRY_NONE);
        retry_limit   = retry_count(cfg[CFG_RETRY_LSB +: 3]);
        retry_allowed = (cfg[CFG_RETRY_LSB +: 3] == RETRY_INF)
                      || (cfg[CFG_RETRY_LSB +: 3] == RETRY_PIN) || (tries < retry_limit);
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_ramps   = ramps;
        next_tries   = tries;
        next_ramp_up = ramp_up;
        next_inrush  = inrush;
        next_tm_hi_q = i_timer_hi;
        next_cb_q    = breaker;
        next_slow_dis = slow_dis;
        ev.oc_evt    = 1'b0;
        ev.cb_evt    = (state == ST_ON) && breaker && !cb_q;
        ev.latched   = (state == ST_LATCHED);
        ev.pgood     = o_power_good_output;
        tmode        = TM_IDLE;
        g_strong     = 1'b0;
        g_weak       = 1'b1;
        g_src        = 1'b0;
        unique case (state)
            ST_OFF: begin
                tmode    = TM_GROUND;
                g_strong = 1'b1;
                g_weak   = 1'b0;
                if (i_por_ok) begin
                    next_state = ST_INSERT;
                end
            end
            ST_INSERT: begin
                tmode = TM_INSERT;
                if (i_timer_hi) begin
                    next_state = ST_WAIT_UV;
                end
            end
            ST_WAIT_UV: begin
                tmode = TM_IDLE;
                if (supply_ok) begin
                    next_state  = ST_ON;
                    next_inrush = 1'b1;
                    next_tries  = '0;
                    next_slow_dis = 1'b0;
                end
            end
            ST_ON: begin
                // Once limiting or a breaker trip has run, the timer charge bleeds off slowly; the charge
                // left over from insertion is still dumped fast before that.
                tmode    = (limiting || breaker || slow_dis) ? TM_FAULT : TM_IDLE;
                g_weak   = 1'b0;
                g_src    = !breaker;
                g_strong = breaker;
                if (i_feedback_sense_above) begin
                    next_inrush = 1'b0;
                end
                if (limiting || breaker) begin
                    next_slow_dis = 1'b1;
                end
                if (!supply_ok) begin
                    g_strong   = 1'b0;
                    g_weak     = 1'b1;
                    g_src      = 1'b0;
                    next_state = ST_WAIT_UV;
                end else if (timer_top) begin
                    ev.oc_evt  = limiting;
                    g_strong   = inrush;
                    g_weak     = !inrush;
                    g_src      = 1'b0;
                    next_state = (policy_latch || !retry_allowed) ? ST_LATCHED : ST_RETRY;
                    next_ramps   = '0;
                    next_ramp_up = 1'b0;
                end
            end
            ST_LATCHED: begin
                tmode = TM_FAULT;
                if (!i_undervoltage_lockout_ok && !i_timer_lo) begin
                    next_state = ST_WAIT_UV;
                end
            end
            ST_RETRY: begin
                tmode = TM_FAULT;
                if (ramp_up && i_timer_hi) begin
                    next_ramp_up = 1'b0;
                end else if (!ramp_up && i_timer_mid
                             && ramps < RESTART_RAMPS - 4'h1) begin
                    next_ramp_up = 1'b0;
                end else if (!ramp_up && !i_timer_mid
                             && ramps < RESTART_RAMPS - 4'h1) begin
                    next_ramp_up = 1'b1;
                    next_ramps   = ramps + 4'h1;
                end else if (!ramp_up && !i_timer_lo) begin
                    next_state  = ST_ON;
                    next_inrush = 1'b1;
                    next_tries  = tries + 5'h01;
                    next_slow_dis = 1'b0;
                end
            end
            default: next_state = ST_OFF;
        endcase
        if (!i_por_ok) begin
            next_state = ST_OFF;
        end else if (i_overvoltage_lockout_high && state == ST_WAIT_UV) begin
            next_state = ST_WAIT_UV;
        end
    end

    timer_drive u_timer (
        .mode       (tmode),
        .limiting   (state == ST_ON ? (limiting || breaker) : 1'b0),
        .retry_up   (state == ST_RETRY && ramp_up),
        .ground     (t_ground),
        .chg_insert (t_insert),
        .chg_fault  (t_fault),
        .dis_fast   (t_dfast),
        .dis_slow   (t_dslow)
    );

    fault_regs u_regs (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .por_ok  (i_por_ok),
        .clear   (i_clear_faults),
        .addr    (i_reg_addr),
        .wr      (i_reg_wr),
        .wdata   (i_reg_wdata),
        .rdata   (rdata),
        .cfg     (cfg),
        .ev      (ev.regs)
    );

    // ------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------
    // All pin drives are registered, so comparator decisions reach the gate, timer and power-good
    // pins one cycle later and the alert pins two cycles later; the analog loops are far slower than that.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state               <= ST_OFF;
            ramps               <= '0;
            tries               <= '0;
            ramp_up             <= 1'b0;
            inrush              <= 1'b0;
            tm_hi_q             <= 1'b0;
            cb_q                <= 1'b0;
            slow_dis            <= 1'b0;
            o_reg_rdata         <= '0;
            o_gate_strong_pd    <= 1'b1;
            o_gate_weak_pd      <= 1'b0;
            o_gate_source       <= 1'b0;
            o_cl_sel_high       <= 1'b0;
            o_cb_sel_high       <= 1'b0;
            o_timer_ground      <= 1'b1;
            o_timer_chg_insert  <= 1'b0;
            o_timer_chg_fault   <= 1'b0;
            o_timer_dis_fast    <= 1'b0;
            o_timer_dis_slow    <= 1'b0;
            o_power_good_output <= 1'b0;
            o_alert_line        <= 1'b0;
            o_alert_line_oe     <= 1'b0;
        end else begin
            state               <= next_state;
            ramps               <= next_ramps;
            tries               <= next_tries;
            ramp_up             <= next_ramp_up;
            inrush              <= next_inrush;
            tm_hi_q             <= next_tm_hi_q;
            cb_q                <= next_cb_q;
            slow_dis            <= next_slow_dis;
            o_reg_rdata         <= rdata;
            o_gate_strong_pd    <= g_strong;
            o_gate_weak_pd      <= g_weak;
            o_gate_source       <= g_src;
            o_cl_sel_high       <= cl_high;
            o_cb_sel_high       <= cb_high;
            o_timer_ground      <= t_ground;
            o_timer_chg_insert  <= t_insert;
            o_timer_chg_fault   <= t_fault;
            o_timer_dis_fast    <= t_dfast;
            o_timer_dis_slow    <= t_dslow;
            o_power_good_output <= i_feedback_sense_above && supply_ok;
            o_alert_line        <= 1'b0;
            o_alert_line_oe     <= ev.alert;
        end
    end

    chk_off_strong_pd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_OFF) |=> (o_gate_strong_pd && o_timer_ground && !o_gate_source))
        else $error("gate or timer not held before power-on");
    chk_insert_gate_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_INSERT) |=> (o_gate_weak_pd && o_timer_chg_insert && !o_gate_source))
        else $error("insertion delay not holding gate off");
    chk_insert_end: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_INSERT && i_timer_hi && i_por_ok) |=> (state == ST_WAIT_UV))
        else $error("insertion delay did not end at timer top");
    chk_turn_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_WAIT_UV && supply_ok && i_por_ok)
        |=> (state == ST_ON && supply_ok && !breaker && !timer_top) |=> o_gate_source)
        else $error("switch not turned on after insertion");
    chk_limit_charge: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_ON && limiting) |=> o_timer_chg_fault)
        else $error("fault timer not charging while limiting");
    chk_uv_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_ON && !supply_ok && i_por_ok) |=> (o_gate_weak_pd && !o_gate_source))
        else $error("lockout did not switch off the gate");
    chk_pgood_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_feedback_sense_above && supply_ok) |=> o_power_good_output)
        else $error("power good not following feedback");
    chk_breaker_pd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_ON && breaker && supply_ok && !timer_top && i_por_ok)
        |=> (o_gate_strong_pd && !o_gate_source))
        else $error("breaker trip did not pull gate down");
    chk_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state == ST_LATCHED) |=> !o_gate_source)
        else $error("gate driven while latched off");
endmodule

// ==== core/hs_seq_pkg.sv ====
package hs_seq_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SUMMARY_FAULT_WORD  = 8'h79;
    localparam logic [7:0] ADDR_INPUT_FAULT_STATUS  = 8'h7C;
    localparam logic [7:0] ADDR_VENDOR_FAULT_STATUS = 8'h80;
    localparam logic [7:0] ADDR_ALERT_SUPPRESS_MASK = 8'hD8;
    localparam logic [7:0] ADDR_PROTECTION_CONFIG   = 8'hD9;
    localparam logic [7:0] ADDR_COMBINED_DIAG_FLAGS = 8'hE1;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_SUM_INPUT     = 13;
    localparam int BIT_SUM_PGOOD_N   = 11;
    localparam int BIT_IN_OC         = 1;
    localparam int BIT_VND_PRESET    = 0;
    localparam int BIT_VND_BREAKER   = 1;
    localparam int BIT_DG_OC         = 5;
    localparam int BIT_DG_BREAKER    = 4;
    localparam int BIT_DG_PGOOD      = 3;
    localparam int BIT_DG_LATCHED    = 2;
    localparam int CFG_RETRY_LSB     = 0;
    localparam int CFG_CL_LSB        = 3;
    localparam int CFG_CB_LSB        = 5;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [7:0]  CFG_RESET  = 8'h00;

    // Retry field codes; zero follows the restart-policy pin.
    localparam logic [2:0] RETRY_PIN  = 3'h0;
    localparam logic [2:0] RETRY_NONE = 3'h1;
    localparam logic [2:0] RETRY_INF  = 3'h7;
    // Override field codes for limit and breaker selection.
    localparam logic [1:0] OVR_PIN  = 2'h0;
    localparam logic [1:0] OVR_LOW  = 2'h1;
    localparam logic [1:0] OVR_HIGH = 2'h2;

    // Falling ramps in one automatic restart.
    localparam logic [3:0] RESTART_RAMPS = 4'h8;

    typedef enum logic [5:0] {
        ST_OFF     = 6'h01,
        ST_INSERT  = 6'h02,
        ST_WAIT_UV = 6'h04,
        ST_ON      = 6'h08,
        ST_LATCHED = 6'h10,
        ST_RETRY   = 6'h20
    } seq_state_t;

    typedef enum logic [1:0] {
        TM_GROUND = 2'h0,
        TM_INSERT = 2'h1,
        TM_FAULT  = 2'h2,
        TM_IDLE   = 2'h3
    } timer_mode_t;
endpackage

// ==== core/timer_drive.sv ====
`timescale 1ns/1ns
module timer_drive
    import hs_seq_pkg::*;
(
    // Mode and comparator
    input  wire timer_mode_t mode,
    input  wire logic        limiting,
    input  wire logic        retry_up,
    // Source selections
    output logic             ground,
    output logic             chg_insert,
    output logic             chg_fault,
    output logic             dis_fast,
    output logic             dis_slow
);
    always_comb begin
        ground     = (mode == TM_GROUND);
        chg_insert = (mode == TM_INSERT);
        chg_fault  = (mode == TM_FAULT) && (limiting || retry_up);
        dis_slow   = (mode == TM_FAULT) && !(limiting || retry_up);
        dis_fast   = (mode == TM_IDLE);
    end
endmodule

// ==== verif/hot_swap_fault_sequencer_tb.sv ====
`timescale 1ns/1ns
module hot_swap_fault_sequencer_tb;
    import hs_seq_pkg::*;
    logic i_clk = 0, i_rst_b = 0, por = 0, uv = 0, cl = 0, pl = 0, cb = 0, fb = 0;
    logic clp = 0, cbp = 0, clr = 0, wr = 0, alert_w;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wd = 16'h0000, rd, got;
    logic        hi, mid, lo, spd, wpd, src, cls, cbs, tg, ci, cf, df, ds, pg, ao, aoe;
    int failures = 0, cmp_count = 0, cyc = 0, seen = 0;
    int unsigned rs = 31774;
    hot_swap_fault_sequencer hot_swap_fault_sequencer_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_por_ok(por), .i_undervoltage_lockout_ok(uv), .i_overvoltage_lockout_high(1'b0),
        .i_timer_hi(hi), .i_timer_mid(mid), .i_timer_lo(lo), .i_cl_low_hit(cl),
        .i_cl_high_hit(1'b0), .i_pl_hit(pl), .i_cb_low_hit(cb), .i_cb_high_hit(1'b0),
        .i_feedback_sense_above(fb), .i_limit_select_pin(clp), .i_breaker_select_pin(cbp),
        .i_retry_pin(1'b1), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
        .i_clear_faults(clr), .o_reg_rdata(rd), .o_gate_strong_pd(spd), .o_gate_weak_pd(wpd),
        .o_gate_source(src), .o_cl_sel_high(cls), .o_cb_sel_high(cbs), .o_timer_ground(tg),
        .o_timer_chg_insert(ci), .o_timer_chg_fault(cf), .o_timer_dis_fast(df),
        .o_timer_dis_slow(ds), .o_power_good_output(pg), .i_alert_line(alert_w),
        .o_alert_line(ao), .o_alert_line_oe(aoe));
    timer_cap_model timer_cap_model_i (.i_clk(i_clk), .i_gnd(tg), .i_chg_ins(ci),
        .i_chg_flt(cf), .i_dis_fast(df), .i_dis_slow(ds), .o_hi(hi), .o_mid(mid), .o_lo(lo));
    // The alert line has a pull-up, so it idles high when nobody pulls it.
    assign alert_w = aoe ? ao : 1'b1;
    initial forever #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    function automatic int unsigned xs(int unsigned x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic sel(int ovr, logic pin);
        return (ovr == 1) ? 1'b0 : (ovr == 2) ? 1'b1 : pin;
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic check(string nm, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_wr(logic [7:0] a, logic [15:0] d);
        @(posedge i_clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a);
        @(posedge i_clk);
        addr <= a;
        tick(2);
        got = rd;
    endtask
    task automatic final_report();
        if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        logic [15:0] r;
        tick(20);
        check("strong_pd", 1, spd);
        check("timer_ground", 1, tg);
        @(posedge i_clk) i_rst_b <= 1'b1;
        @(posedge i_clk) begin
            por <= 1'b1;
            uv <= 1'b1;
        end
        tick(4);
        check("insert", 3'b110, {wpd, ci, src});
        check("alert", 0, alert_w);
        reg_rd(ADDR_VENDOR_FAULT_STATUS);
        check("preset", 1, got[BIT_VND_PRESET]);
        for (int i = 0; i < 400 && src !== 1'b1; i++) begin
            tick(1);
            if (df === 1'b1) seen = 1;
        end
        check("dis_fast", 1, seen[0]);
        check("switch_on", 1, src);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk) if (k == 0) cl <= 1'b1; else pl <= 1'b1;
            tick(5);
            check("chg_fault", 1, cf);
            @(posedge i_clk) {cl, pl} <= 2'b00;
            tick(3);
            check("recover", 3'b101, {ds, cf, src});
        end
        @(posedge i_clk) fb <= 1'b1;
        tick(3);
        check("power_good", 1, pg);
        for (int o = 0; o < 3; o++) begin
            rs = xs(rs);
            @(posedge i_clk) {clp, cbp} <= rs[1:0];
            reg_wr(ADDR_PROTECTION_CONFIG, {9'h000, o[1:0], o[1:0], 3'h1});
            reg_rd(ADDR_PROTECTION_CONFIG);
            check("cfg", {9'h000, o[1:0], o[1:0], 3'h1}, got);
            check("cl_sel", sel(o, clp), cls);
            check("cb_sel", sel(o, cbp), cbs);
        end
        rs = xs(rs);
        r = rs[15:0];
        reg_wr(ADDR_ALERT_SUPPRESS_MASK, r);
        reg_rd(ADDR_ALERT_SUPPRESS_MASK);
        check("mask", r, got);
        reg_wr(ADDR_ALERT_SUPPRESS_MASK, MASK_RESET);
        reg_wr(ADDR_PROTECTION_CONFIG, 16'h0001);
        @(posedge i_clk) begin
            cbp <= 1'b0;
            cb <= 1'b1;
        end
        tick(3);
        check("breaker_pd", 1, spd);
        @(posedge i_clk) cb <= 1'b0;
        tick(3);
        check("breaker_release", 0, spd);
        reg_rd(ADDR_VENDOR_FAULT_STATUS);
        check("vnd_breaker", 1, got[BIT_VND_BREAKER]);
        reg_rd(ADDR_COMBINED_DIAG_FLAGS);
        check("diag_breaker", 1, got[BIT_DG_BREAKER]);
        @(posedge i_clk) clr <= 1'b1;
        @(posedge i_clk) clr <= 1'b0;
        reg_rd(ADDR_VENDOR_FAULT_STATUS);
        check("cleared", 0, got[1:0]);
        @(posedge i_clk) uv <= 1'b0;
        tick(3);
        check("uv_off", 2'b01, {src, wpd});
        @(posedge i_clk) {uv, fb, cl, clp} <= 4'b1010;
        tick(3);
        check("restart_on", 1, src);
        for (int i = 0; i < 100 && src === 1'b1; i++) tick(1);
        check("inrush_fault", 3'b100, {spd, wpd, src});
        reg_rd(ADDR_INPUT_FAULT_STATUS);
        check("in_oc", 1, got[BIT_IN_OC]);
        reg_rd(ADDR_COMBINED_DIAG_FLAGS);
        check("diag_oc_latch", 2'b11, {got[BIT_DG_OC], got[BIT_DG_LATCHED]});
        check("oc_alert", 0, alert_w);
        final_report();
    end
endmodule

// ==== verif/timer_cap_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Timer capacitor model
// ----------------------------------------------------------------
// The charge rates are scaled so that the insertion delay takes 170 cycles.
module timer_cap_model (
    // Clock and drive selections
    input  wire logic i_clk,
    input  wire logic i_gnd,
    input  wire logic i_chg_ins,
    input  wire logic i_chg_flt,
    input  wire logic i_dis_fast,
    input  wire logic i_dis_slow,
    // Threshold comparators
    output logic      o_hi,
    output logic      o_mid,
    output logic      o_lo
);
    int lvl = 0;
    int n;
    assign n = lvl + (i_chg_ins ? 1 : 0) + (i_chg_flt ? 4 : 0)
             - (i_dis_fast ? 20 : 0) - (i_dis_slow ? 1 : 0);
    always @(posedge i_clk) begin
        lvl <= (i_gnd || n < 0) ? 0 : n;
    end
    assign o_hi  = (lvl >= 170);
    assign o_mid = (lvl >= 100);
    assign o_lo  = (lvl >= 30);
endmodule
